/* File: hw/di_edge_if.sv */
// Synchronised input levels and edges passed from sampler to decoder
`timescale 1ns/1ps

interface di_edge_if;
  import drive_cmd_pkg::*;
  logic [NUM_IN-1:0] level;
  logic [NUM_IN-1:0] rise;
  logic [NUM_IN-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : di_edge_if

/* File: hw/di_sampler.sv */
// Two-stage input synchroniser with edge detection
`timescale 1ns/1ps

module di_sampler
  import drive_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              reset_in,
  // Raw inputs and sampled result
  input  wire logic [NUM_IN-1:0] di_in,
  di_edge_if.src                 edges
);

  logic [NUM_IN-1:0] meta_r;
  logic [NUM_IN-1:0] sync_r;
  logic [NUM_IN-1:0] prev_r;

  // First stage is read only by the second
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end
    else
    begin
      meta_r <= di_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign edges.level = sync_r;
  assign edges.rise  = sync_r & ~prev_r;
  assign edges.fall  = ~sync_r & prev_r;

endmodule : di_sampler

/* File: hw/drive_cmd_pkg.sv */
// Constants, types and decode helpers for the drive command input decoder
//------------------------------------------------------------------------
// Contract
//------------------------------------------------------------------------

package drive_cmd_pkg;

  localparam int NUM_IN = 4;

  typedef logic [6:0]              fn_code_t;
  typedef logic [NUM_IN-1:0][6:0]  fn_table_t;
  typedef logic [2:0]              src_code_t;
  typedef logic [1:0]              wire_code_t;
  typedef logic [2:0]              cfg_addr_t;

  // Input function codes
  localparam fn_code_t FN_DISABLED  = 7'h00;
  localparam fn_code_t FN_RUN       = 7'h01;
  localparam fn_code_t FN_REV_RUN   = 7'h02;
  localparam fn_code_t FN_COAST     = 7'h03;
  localparam fn_code_t FN_QUICK     = 7'h04;
  localparam fn_code_t FN_FAULT_ACK = 7'h09;
  localparam fn_code_t FN_INCH_R    = 7'h0A;
  localparam fn_code_t FN_INCH_L    = 7'h0B;
  localparam fn_code_t FN_REVERSE   = 7'h0C;
  localparam fn_code_t FN_POT_UP    = 7'h0D;
  localparam fn_code_t FN_POT_DN    = 7'h0E;
  localparam fn_code_t FN_FIX_B0    = 7'h0F;
  localparam fn_code_t FN_FIX_B1    = 7'h10;
  localparam fn_code_t FN_FIX_B2    = 7'h11;
  localparam fn_code_t FN_FIX_B3    = 7'h12;
  localparam fn_code_t FN_QSRC1     = 7'h16;
  localparam fn_code_t FN_QSRC2     = 7'h17;
  localparam fn_code_t FN_DC_BRAKE  = 7'h19;
  localparam fn_code_t FN_PID       = 7'h1B;
  localparam fn_code_t FN_EXT_TRIP  = 7'h1D;
  localparam fn_code_t FN_ADD_DIS   = 7'h21;
  localparam fn_code_t FN_FREE      = 7'h63;

  // Command source, wire method, setpoint source and access codes
  localparam src_code_t  SRC_FACTORY  = 3'h0;
  localparam src_code_t  SRC_INPUTS   = 3'h2;
  localparam src_code_t  SRC_SERIAL   = 3'h4;
  localparam src_code_t  SRC_FIELDBUS = 3'h6;
  localparam wire_code_t WIRE_3W_M2   = 2'h3;
  localparam src_code_t  SP_NONE      = 3'h0;
  localparam src_code_t  SP_FIXED     = 3'h3;
  localparam src_code_t  SP_FIELDBUS  = 3'h6;
  localparam logic [1:0] ACCESS_EXT   = 2'h2;

  // Configuration port addresses
  localparam cfg_addr_t CFG_CMD_SRC  = 3'h4;
  localparam cfg_addr_t CFG_WIRE     = 3'h5;
  localparam cfg_addr_t CFG_SETPOINT = 3'h6;

  // Values after reset or factory restore
  localparam fn_table_t  RST_FN_TABLE = {FN_FIX_B0, FN_FAULT_ACK,
                                         FN_REVERSE, FN_RUN};
  localparam wire_code_t RST_WIRE     = 2'h0;
  localparam src_code_t  RST_SETPOINT = SP_FIXED;

  typedef enum logic [1:0] {
    ST_STOPPED = 2'b00,
    ST_RUNNING = 2'b01,
    ST_RAMPING = 2'b11
  } run_state_t;

  typedef struct packed {
    logic              run_lvl;
    logic              run_rise;
    logic              revrun_lvl;
    logic              coast;
    logic              quick;
    logic              inch_r;
    logic              inch_l;
    logic              dir_lvl;
    logic              dir_rise;
    logic              dir_fall;
    logic              pot_up;
    logic              pot_dn;
    logic              fault_ack;
    logic [3:0]        fix_sel;
    logic              qsrc1;
    logic              qsrc2;
    logic              dc_brake;
    logic              pid;
    logic              trip;
    logic              add_dis;
    logic [NUM_IN-1:0] free;
  } fn_out_t;

  function automatic logic [NUM_IN-1:0] fn_mask(input fn_table_t t,
                                                input fn_code_t  c);
    logic [NUM_IN-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_IN; i++)
      m[i] = (t[i] == c);
    return m;
  endfunction : fn_mask

  function automatic logic fn_hit(input fn_table_t         t,
                                  input fn_code_t          c,
                                  input logic [NUM_IN-1:0] v);
    return |(fn_mask(t, c) & v);
  endfunction : fn_hit

  function automatic logic fn_valid(input fn_code_t c);
    case (c)
      FN_DISABLED, FN_RUN, FN_REV_RUN, FN_COAST, FN_QUICK, FN_FAULT_ACK,
      FN_INCH_R, FN_INCH_L, FN_REVERSE, FN_POT_UP, FN_POT_DN,
      FN_FIX_B0, FN_FIX_B1, FN_FIX_B2, FN_FIX_B3, FN_QSRC1, FN_QSRC2,
      FN_DC_BRAKE, FN_PID, FN_EXT_TRIP, FN_ADD_DIS, FN_FREE:
        return 1'b1;
      default:
        return 1'b0;
    endcase
  endfunction : fn_valid

endpackage : drive_cmd_pkg

/* File: hw/drive_command_input_decoder.sv */
// Top level: configuration store, command gating and run/direction control
`timescale 1ns/1ps

module drive_command_input_decoder
  import drive_cmd_pkg::*;
#(
  parameter bit HAS_FIELDBUS = 1'b1
)
(
  // Clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              reset_in,
  // Digital inputs and drive status
  input  wire logic [NUM_IN-1:0] di_in,
  input  wire logic              motor_rotating_in,
  // Configuration port
  input  wire logic              cfg_wr_in,
  input  wire cfg_addr_t         cfg_addr_in,
  input  wire fn_code_t          cfg_data_in,
  input  wire logic              factory_restore_in,
  input  wire logic [1:0]        parameter_access_level_in,
  // Motor commands
  output logic                   run_out,
  output logic                   reverse_out,
  output logic                   coast_stop_out,
  output logic                   quick_ramp_stop_out,
  output logic                   inch_run_right_out,
  output logic                   inch_run_left_out,
  output logic                   motor_potentiometer_up_out,
  output logic                   motor_potentiometer_down_out,
  output logic                   fault_ack_out,
  output logic [3:0]             fixed_freq_sel_out,
  output logic                   quick_src1_out,
  output logic                   quick_src2_out,
  output logic                   dc_brake_out,
  output logic                   pid_enable_out,
  output logic                   ext_trip_out,
  output logic [NUM_IN-1:0]      free_inputs_out,
  // Configuration status
  output src_code_t              command_source_select_out,
  output wire_code_t             wire_method_select_out,
  output src_code_t              setpoint_source_select_out,
  output logic                   add_setpoint_en_out,
  output fn_table_t              input_function_out,
  output logic                   cfg_reject_out
);

  localparam src_code_t RST_CMD_SRC = HAS_FIELDBUS ? SRC_FIELDBUS
                                                   : SRC_FACTORY;

  //----------------------------------------------------------------------
  // Input sampling and function decode
  //----------------------------------------------------------------------

  di_edge_if edges ();
  fn_out_t   dec;
  fn_table_t input_function_r;

  di_sampler u_sampler (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .di_in      (di_in),
    .edges      (edges)
  );

  fn_decoder u_decoder (
    .fn_table_in (input_function_r),
    .edges       (edges),
    .cmd_out     (dec)
  );

  //----------------------------------------------------------------------
  // Configuration store
  //----------------------------------------------------------------------

  src_code_t  command_source_select_r;
  wire_code_t wire_method_select_r;
  src_code_t  setpoint_source_select_r;
  logic       cfg_reject_r;
  logic [1:0] fn_idx;
  logic       fn_write_ok;
  logic       src_ok;
  logic       sp_ok;

  assign fn_idx = cfg_addr_in[1:0];

  // Level 1 access only reaches the command source, wire method and setpoint selectors
  assign fn_write_ok = (parameter_access_level_in >= ACCESS_EXT) &&
                       (input_function_r[fn_idx] != FN_FREE) &&
                       fn_valid(cfg_data_in);

  assign src_ok = (cfg_data_in == 7'(SRC_FACTORY)) ||
                  (cfg_data_in == 7'(SRC_INPUTS)) ||
                  (cfg_data_in == 7'(SRC_SERIAL)) ||
                  (cfg_data_in == 7'(SRC_FIELDBUS));

  assign sp_ok = (cfg_data_in <= 7'(SRC_SERIAL)) ||
                 (cfg_data_in == 7'(SP_FIELDBUS));

  always_ff @(posedge ref_clk_in)
  begin
    cfg_reject_r <= 1'b0;
    if (reset_in || factory_restore_in)
    begin
      input_function_r         <= RST_FN_TABLE;
      command_source_select_r  <= RST_CMD_SRC;
      wire_method_select_r     <= RST_WIRE;
      setpoint_source_select_r <= RST_SETPOINT;
    end
    else if (cfg_wr_in)
    begin
      if (cfg_addr_in < CFG_CMD_SRC)
      begin
        if (fn_write_ok)
          input_function_r[fn_idx] <= cfg_data_in;
        else
          cfg_reject_r <= 1'b1;
      end
      else if (cfg_addr_in == CFG_CMD_SRC)
      begin
        if (src_ok)
          command_source_select_r <= cfg_data_in[2:0];
        else
          cfg_reject_r <= 1'b1;
      end
      else if (cfg_addr_in == CFG_WIRE)
      begin
        if (cfg_data_in[6:2] == 5'h00)
          wire_method_select_r <= cfg_data_in[1:0];
        else
          cfg_reject_r <= 1'b1;
      end
      else if (cfg_addr_in == CFG_SETPOINT)
      begin
        if (sp_ok)
          setpoint_source_select_r <= cfg_data_in[2:0];
        else
          cfg_reject_r <= 1'b1;
      end
      else
        cfg_reject_r <= 1'b1;
    end
  end

  //----------------------------------------------------------------------
  // Run and direction control
  //----------------------------------------------------------------------

  run_state_t state_r;
  logic       run_r;
  logic       reverse_r;
  logic       from_inputs;
  logic       m2_mode;
  logic       enable;

  assign from_inputs = (command_source_select_r == SRC_INPUTS);
  assign m2_mode     = from_inputs &&
                       (wire_method_select_r == WIRE_3W_M2);
  // Code 2 doubles as the permanent enable in three-wire method two
  assign enable      = dec.revrun_lvl;

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in || !from_inputs)
    begin
      state_r   <= ST_STOPPED;
      run_r     <= 1'b0;
      reverse_r <= 1'b0;
    end
    else if (!m2_mode)
    begin
      // Other wire methods: plain level control, no edge handling
      state_r   <= ST_STOPPED;
      run_r     <= dec.run_lvl | dec.revrun_lvl;
      reverse_r <= dec.revrun_lvl ^ dec.dir_lvl;
    end
    else
    begin
      case (state_r)
        ST_STOPPED:
        begin
          run_r <= 1'b0;
          if (enable && dec.run_rise)
          begin
            state_r   <= ST_RUNNING;
            run_r     <= 1'b1;
            reverse_r <= dec.dir_lvl;
          end
        end
        ST_RUNNING:
        begin
          if (!enable)
          begin
            state_r <= ST_RAMPING;
            run_r   <= 1'b0;
          end
          else if (dec.dir_fall)
            reverse_r <= 1'b0;
          else if (dec.dir_rise)
            reverse_r <= 1'b1;
        end
        ST_RAMPING:
        begin
          // Stays stopping until the drive reports standstill
          run_r <= 1'b0;
          if (!motor_rotating_in)
            state_r <= ST_STOPPED;
        end
        default:
        begin
          state_r <= ST_STOPPED;
          run_r   <= 1'b0;
        end
      endcase
    end
  end

  //----------------------------------------------------------------------
  // Auxiliary commands
  //----------------------------------------------------------------------

  fn_out_t aux_r;
  logic    add_en_r;

  // Commands act only while the inputs are the command source
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in || !from_inputs)
      aux_r <= '0;
    else
      aux_r <= dec;
  end

  // Additional setpoints are summed when a setpoint source is selected, unless an input disables them while the inputs are the command source
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      add_en_r <= 1'b0;
    else
      add_en_r <= (setpoint_source_select_r != SP_NONE) &&
                  !(from_inputs && dec.add_dis);
  end

  assign run_out                      = run_r;
  assign reverse_out                  = reverse_r;
  assign coast_stop_out               = aux_r.coast;
  assign quick_ramp_stop_out          = aux_r.quick;
  assign inch_run_right_out           = aux_r.inch_r;
  assign inch_run_left_out            = aux_r.inch_l;
  assign motor_potentiometer_up_out   = aux_r.pot_up;
  assign motor_potentiometer_down_out = aux_r.pot_dn;
  assign fault_ack_out                = aux_r.fault_ack;
  assign fixed_freq_sel_out           = aux_r.fix_sel;
  assign quick_src1_out               = aux_r.qsrc1;
  assign quick_src2_out               = aux_r.qsrc2;
  assign dc_brake_out                 = aux_r.dc_brake;
  assign pid_enable_out               = aux_r.pid;
  assign ext_trip_out                 = aux_r.trip;
  assign free_inputs_out              = aux_r.free;
  assign command_source_select_out    = command_source_select_r;
  assign wire_method_select_out       = wire_method_select_r;
  assign setpoint_source_select_out   = setpoint_source_select_r;
  assign add_setpoint_en_out          = add_en_r;
  assign input_function_out           = input_function_r;
  assign cfg_reject_out               = cfg_reject_r;

  //----------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  logic [NUM_IN-1:0] free_now;
  assign free_now = fn_mask(input_function_r, FN_FREE);

  AST_STOP_ON_ENABLE_LOW: assert property (
    (m2_mode && state_r == ST_RUNNING && !enable) |=>
      (!run_out && state_r == ST_RAMPING)[*1] ##1 !run_out)
    else $error("enable loss while running did not ramp stop");

  AST_NO_ACTION_AT_STANDSTILL: assert property (
    (m2_mode && state_r == ST_STOPPED && !enable) |=>
      (state_r == ST_STOPPED && !run_out))
    else $error("enable low at standstill changed the drive");

  AST_START_SENSE: assert property (
    (m2_mode && state_r == ST_STOPPED && enable && dec.run_rise) |=>
      (run_out && reverse_out == $past(dec.dir_lvl)))
    else $error("start did not follow the direction input");

  AST_REVERSE_ON_FALL: assert property (
    (m2_mode && state_r == ST_RUNNING && enable && dec.dir_fall) |=>
      (!reverse_out && run_out))
    else $error("direction fall did not reverse to setpoint");

  AST_REVERSE_ON_RISE: assert property (
    (m2_mode && state_r == ST_RUNNING && enable && dec.dir_rise) |=>
      (reverse_out && run_out))
    else $error("direction rise did not reverse to inverted setpoint");

  AST_DIR_IDLE_AT_STANDSTILL: assert property (
    (m2_mode && state_r == ST_STOPPED && !dec.run_rise &&
     (dec.dir_rise || dec.dir_fall)) |=>
      (!run_out && $stable(reverse_out)))
    else $error("direction edge at standstill had an effect");

  AST_FREE_STICKS: assert property (
    !factory_restore_in |=> (($past(free_now) & ~free_now) == 4'h0))
    else $error("freed input left code 99 without factory restore");

  AST_ACCESS_GUARD: assert property (
    (cfg_wr_in && !factory_restore_in && cfg_addr_in < CFG_CMD_SRC &&
     parameter_access_level_in < ACCESS_EXT) |=>
      ($stable(input_function_r) && cfg_reject_out))
    else $error("input function changed without extended access");

  AST_SOURCE_GATE: assert property (
    (command_source_select_r != SRC_INPUTS) |=> (!run_out && !aux_r.coast))
    else $error("input commands acted with another source selected");

  AST_RESET_VALUES: assert property (
    $fell(reset_in) |->
      (command_source_select_r == RST_CMD_SRC &&
       input_function_r == RST_FN_TABLE &&
       setpoint_source_select_r == SP_FIXED))
    else $error("configuration not at reset values");

  COV_START: cover property (
    m2_mode && state_r == ST_STOPPED ##1 state_r == ST_RUNNING);
  COV_REVERSAL: cover property (
    m2_mode && state_r == ST_RUNNING && dec.dir_rise ##1 reverse_out);
  COV_RAMP_DONE: cover property (
    state_r == ST_RAMPING ##1 state_r == ST_STOPPED);
  COV_FREE_LOCK: cover property (
    (free_now != 4'h0) && cfg_wr_in && cfg_reject_out == 1'b0);

endmodule : drive_command_input_decoder

/* File: hw/fn_decoder.sv */
// Maps each input through its function code onto control commands
`timescale 1ns/1ps

module fn_decoder
  import drive_cmd_pkg::*;
(
  // Per-input function codes
  input  wire fn_table_t fn_table_in,
  // Sampled inputs
  di_edge_if.dst         edges,
  // Decoded commands
  output fn_out_t        cmd_out
);

  fn_table_t         t;
  logic [NUM_IN-1:0] v;

  assign t = fn_table_in;
  assign v = edges.level;

  always_comb
  begin
    cmd_out            = '0;
    cmd_out.run_lvl    = fn_hit(t, FN_RUN, v);
    cmd_out.run_rise   = fn_hit(t, FN_RUN, edges.rise);
    cmd_out.revrun_lvl = fn_hit(t, FN_REV_RUN, v);
    cmd_out.coast      = fn_hit(t, FN_COAST, v);
    cmd_out.quick      = fn_hit(t, FN_QUICK, v);
    cmd_out.inch_r     = fn_hit(t, FN_INCH_R, v);
    cmd_out.inch_l     = fn_hit(t, FN_INCH_L, v);
    cmd_out.dir_lvl    = fn_hit(t, FN_REVERSE, v);
    cmd_out.dir_rise   = fn_hit(t, FN_REVERSE, edges.rise);
    cmd_out.dir_fall   = fn_hit(t, FN_REVERSE, edges.fall);
    cmd_out.pot_up     = fn_hit(t, FN_POT_UP, v);
    cmd_out.pot_dn     = fn_hit(t, FN_POT_DN, v);
    cmd_out.fault_ack  = fn_hit(t, FN_FAULT_ACK, v);
    cmd_out.fix_sel[0] = fn_hit(t, FN_FIX_B0, v);
    cmd_out.fix_sel[1] = fn_hit(t, FN_FIX_B1, v);
    cmd_out.fix_sel[2] = fn_hit(t, FN_FIX_B2, v);
    cmd_out.fix_sel[3] = fn_hit(t, FN_FIX_B3, v);
    cmd_out.qsrc1      = fn_hit(t, FN_QSRC1, v);
    cmd_out.qsrc2      = fn_hit(t, FN_QSRC2, v);
    cmd_out.dc_brake   = fn_hit(t, FN_DC_BRAKE, v);
    cmd_out.pid        = fn_hit(t, FN_PID, v);
    cmd_out.trip       = fn_hit(t, FN_EXT_TRIP, v);
    cmd_out.add_dis    = fn_hit(t, FN_ADD_DIS, v);
    cmd_out.free       = fn_mask(t, FN_FREE);
  end

endmodule : fn_decoder

/* File: tb/drive_command_input_decoder_tb.sv */
// Self-checking bench for the drive command input decoder
`timescale 1ns/1ps

module drive_command_input_decoder_tb;
  import drive_cmd_pkg::*;
  logic              ref_clk_in = 1'b0;
  logic              reset_in   = 1'b1;
  logic [NUM_IN-1:0] sw         = '0;
  logic              cfg_wr     = 1'b0;
  logic              restore    = 1'b0;
  cfg_addr_t         addr       = '0;
  fn_code_t          data       = '0;
  logic [1:0]        access     = 2'h2;
  logic [NUM_IN-1:0] di, free;
  logic [3:0]        fix;
  logic rot, run, rev, coast, quick, inr, inl, pup, pdn, fack;
  logic qs1, qs2, brk, pid, trip, addsp, rej;
  src_code_t         csrc, sp;
  wire_code_t        wm;
  fn_table_t         ftab;
  logic [15:0]       aux;
  int                mismatches = 0;
  int                n_tests    = 0;

  assign aux = {coast, quick, inr, inl, pup, pdn, fack, fix,
                qs1, qs2, brk, pid, trip};

  input_panel_model input_panel_model_inst (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .switch_in(sw),
    .run_in(run), .di_out(di), .motor_rotating_out(rot));

  drive_command_input_decoder drive_command_input_decoder_inst (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .di_in(di),
    .motor_rotating_in(rot), .cfg_wr_in(cfg_wr), .cfg_addr_in(addr),
    .cfg_data_in(data), .factory_restore_in(restore),
    .parameter_access_level_in(access), .run_out(run),
    .reverse_out(rev), .coast_stop_out(coast),
    .quick_ramp_stop_out(quick), .inch_run_right_out(inr),
    .inch_run_left_out(inl), .motor_potentiometer_up_out(pup),
    .motor_potentiometer_down_out(pdn), .fault_ack_out(fack),
    .fixed_freq_sel_out(fix), .quick_src1_out(qs1),
    .quick_src2_out(qs2), .dc_brake_out(brk), .pid_enable_out(pid),
    .ext_trip_out(trip), .free_inputs_out(free),
    .command_source_select_out(csrc), .wire_method_select_out(wm),
    .setpoint_source_select_out(sp), .add_setpoint_en_out(addsp),
    .input_function_out(ftab), .cfg_reject_out(rej));

  always #10 ref_clk_in = ~ref_clk_in;

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // The refusal pulse is looked for over the two edges after the write
  task automatic put(input cfg_addr_t a, input fn_code_t d, input logic e);
    logic r;
    cyc(1);
    cfg_wr = 1'b1;
    addr = a;
    data = d;
    cyc(1);
    cfg_wr = 1'b0;
    r = rej;
    cyc(1);
    chk(r | rej, e);
  endtask : put

  // Pin change needs two sync edges and an output register
  task automatic pin(input int i, input logic v);
    cyc(1);
    sw[i] = v;
    cyc(4);
  endtask : pin

  task automatic t_reset;
    chk(csrc, SRC_FIELDBUS);
    chk(ftab, RST_FN_TABLE);
    chk({sp, wm}, {RST_SETPOINT, RST_WIRE});
    $display("test reset done");
  endtask : t_reset

  task automatic t_cfg;
    for (int s = 0; s < 8; s++)
    begin
      put(CFG_CMD_SRC, 7'(s), s[0] | s[2] & s[1] & s[0]);
      put(CFG_SETPOINT, 7'(s), s == 5 || s == 7);
    end
    chk({csrc, sp}, {SRC_FIELDBUS, SP_FIELDBUS});
    put(3'h7, FN_RUN, 1'b1);
    access = 2'h1;
    put(3'h0, FN_REV_RUN, 1'b1);
    put(CFG_SETPOINT, 7'(SP_FIXED), 1'b0);
    chk(sp, SP_FIXED);
    access = 2'h2;
    $display("test config done");
  endtask : t_cfg

  task automatic t_three_wire;
    put(CFG_CMD_SRC, 7'(SRC_INPUTS), 1'b0);
    put(CFG_WIRE, 7'(WIRE_3W_M2), 1'b0);
    put(CFG_WIRE, 7'h04, 1'b1);
    chk(wm, WIRE_3W_M2);
    put(3'h0, FN_REV_RUN, 1'b0);
    put(3'h1, FN_RUN, 1'b0);
    put(3'h2, FN_REVERSE, 1'b0);
    pin(2, 1'b1);
    pin(1, 1'b1);
    chk(run, 1'b0);
    pin(1, 1'b0);
    pin(0, 1'b1);
    pin(1, 1'b1);
    chk({run, rev}, 2'b11);
    pin(2, 1'b0);
    chk({run, rev}, 2'b10);
    pin(1, 1'b0);
    pin(1, 1'b1);
    chk({run, rev}, 2'b10);
    pin(2, 1'b1);
    chk({run, rev}, 2'b11);
    pin(0, 1'b0);
    chk(run, 1'b0);
    cyc(12);
    pin(1, 1'b0);
    pin(2, 1'b0);
    pin(0, 1'b1);
    pin(1, 1'b1);
    chk({run, rev}, 2'b10);
    $display("test three wire done");
  endtask : t_three_wire

  task automatic t_codes;
    fn_code_t codes[16] = '{FN_COAST, FN_QUICK, FN_INCH_R, FN_INCH_L,
      FN_POT_UP, FN_POT_DN, FN_FAULT_ACK, FN_FIX_B3, FN_FIX_B2, FN_FIX_B1,
      FN_FIX_B0, FN_QSRC1, FN_QSRC2, FN_DC_BRAKE, FN_PID, FN_EXT_TRIP};
    pin(3, 1'b1);
    for (int k = 0; k < 16; k++)
    begin
      put(3'h3, codes[k], 1'b0);
      cyc(2);
      chk(aux, 32'h1 << (15 - k));
    end
    put(3'h3, FN_ADD_DIS, 1'b0);
    cyc(2);
    chk({addsp, aux}, 17'h00000);
    put(3'h3, FN_DISABLED, 1'b0);
    cyc(2);
    chk({addsp, aux}, 17'h10000);
    $display("test codes done");
  endtask : t_codes

  task automatic t_free;
    put(3'h3, FN_FREE, 1'b0);
    cyc(2);
    chk(free, 4'h8);
    put(3'h3, FN_RUN, 1'b1);
    chk(ftab[3], FN_FREE);
    restore = 1'b1;
    cyc(1);
    restore = 1'b0;
    cyc(1);
    chk({ftab, csrc}, {RST_FN_TABLE, SRC_FIELDBUS});
    put(3'h3, FN_RUN, 1'b0);
    $display("test free input done");
  endtask : t_free

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    cyc(5);
    reset_in = 1'b0;
    t_reset();
    t_cfg();
    t_three_wire();
    t_codes();
    t_free();
    tally_and_finish();
  end
endmodule : drive_command_input_decoder_tb

/* File: tb/input_panel_model.sv */
// Switch panel and motor model on the far side of the decoder
`timescale 1ns/1ps

module input_panel_model
  import drive_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              reset_in,
  // Switch settings and motor command
  input  wire logic [NUM_IN-1:0] switch_in,
  input  wire logic              run_in,
  // Pins towards the decoder
  output logic [NUM_IN-1:0]      di_out,
  output logic                   motor_rotating_out
);
  logic [2:0] speed_r;

  // Switches drive the pins as levels; routing is set by the bench
  assign di_out = switch_in;

  // Speed winds down over several cycles so the ramp stop is visible
  always_ff @(posedge ref_clk_in)
    if (reset_in)
      speed_r <= 3'h0;
    else if (run_in && speed_r != 3'h7)
      speed_r <= speed_r + 3'h1;
    else if (!run_in && speed_r != 3'h0)
      speed_r <= speed_r - 3'h1;

  assign motor_rotating_out = (speed_r != 3'h0);
endmodule : input_panel_model
